// ===== rtl/led_pwm_defines.vh
// Constants for the LED PWM intensity controller
`ifndef LED_PWM_DEFINES_VH
`define LED_PWM_DEFINES_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_INPUT_PORTS   8'h00
`define REG_MASTER_AUX    8'h0E
`define REG_INTENSITY_A   8'h10
`define REG_INTENSITY_B   8'h11
`define REG_INTENSITY_C   8'h12
`define REG_INTENSITY_D   8'h13

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define MASTER_AUX_RESET  8'h00
`define INTENSITY_RESET   8'h00
`define MASTER_MSB        7
`define MASTER_LSB        4
`define NIBBLE_W          4
`define STATIC_SETTING    4'hF
`define MASTER_OFF        4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_HZ          10000000
`define OSC_HZ            32000
`define OSC_DIV           (`CLOCK_HZ / `OSC_HZ)
`define SLOTS_PER_PERIOD  15
`define CYCLES_PER_SLOT   16

`endif

// ===== rtl/pwm_slot_timer.v
// Oscillator tick divider and slot/cycle counters for the PWM period

`include "led_pwm_defines.vh"

module pwm_slot_timer #(
   parameter integer DIV    = `OSC_DIV,
   parameter integer SLOTS  = `SLOTS_PER_PERIOD,
   parameter integer CYCLES = `CYCLES_PER_SLOT
) (
   input  wire       i_clock,
   input  wire       i_resetn,
   input  wire       i_run,
   output reg  [3:0] o_cycle,
   output reg  [3:0] o_slot
);

   reg  [9:0] div_r;
   wire       tick;

   assign tick = (div_r == DIV[9:0] - 10'h001);

   // --------------------------------------------------------------------
   // Oscillator stand-in
   // --------------------------------------------------------------------
   // Stopped and cleared while PWM is off, so a restart begins at slot 0
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         div_r   <= 10'h000;
         o_cycle <= 4'h0;
         o_slot  <= 4'h0;
      end else if (!i_run) begin
         div_r   <= 10'h000;
         o_cycle <= 4'h0;
         o_slot  <= 4'h0;
      end else if (tick) begin
         div_r <= 10'h000;
         if (o_cycle == CYCLES[3:0] - 4'h1) begin
            o_cycle <= 4'h0;
            if (o_slot == SLOTS[3:0] - 4'h1)
               o_slot <= 4'h0;
            else
               o_slot <= o_slot + 4'h1;
         end else begin
            o_cycle <= o_cycle + 4'h1;
         end
      end else begin
         div_r <= div_r + 10'h001;
      end
   end

endmodule // pwm_slot_timer

// ===== rtl/led_pwm_intensity_control.v
// LED PWM intensity control for eight open-drain port outputs and a ninth output

`include "led_pwm_defines.vh"

module led_pwm_intensity_control #(
   parameter integer DIV    = `OSC_DIV,
   parameter integer PORTS  = 8
) (
   input  wire             i_clock,
   input  wire             i_resetn,
   // Register access port
   input  wire             i_reg_wr,
   input  wire             i_reg_rd,
   input  wire [7:0]       i_reg_addr,
   input  wire [7:0]       i_reg_wdata,
   output reg  [7:0]       o_reg_rdata,
   // Configuration bits held elsewhere in the device
   input  wire             i_global_enable,
   input  wire             i_blink_enable,
   input  wire             i_blink_flip,
   input  wire [PORTS-1:0] i_phase0,
   input  wire [PORTS-1:0] i_phase1,
   input  wire             i_ninth_phase0,
   input  wire             i_ninth_phase1,
   // Open-drain port pins
   input  wire [PORTS-1:0] i_port_pin,
   output wire [PORTS-1:0] o_port_out,
   output reg  [PORTS-1:0] o_port_oe,
   // Open-drain ninth output
   input  wire             i_ninth_output_pin,
   output wire             o_ninth_output_out,
   output reg              o_ninth_output_oe
);

   // --------------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------------
   reg  [7:0]       master_and_aux_intensity_r;
   reg  [7:0]       output_intensity_a_r;
   reg  [7:0]       output_intensity_b_r;
   reg  [7:0]       output_intensity_c_r;
   reg  [7:0]       output_intensity_d_r;
   reg  [PORTS-1:0] pin_meta_r;
   reg  [PORTS-1:0] pin_sync_r;
   reg              ninth_meta_r;
   reg              ninth_sync_r;
   reg  [7:0]       rdata_nxt;

   wire [3:0]       master_field;
   wire [3:0]       aux_field;
   wire             pwm_run;
   wire [3:0]       cycle;
   wire [3:0]       slot;
   wire             slot_gated;
   wire [PORTS-1:0] port_drive_nxt;
   wire             ninth_drive_nxt;

   // Open-drain: the pin only ever sinks, the enable carries the level
   assign o_port_out         = {PORTS{1'b0}};
   assign o_ninth_output_out = 1'b0;

   assign master_field = master_and_aux_intensity_r[`MASTER_MSB:`MASTER_LSB];
   assign aux_field    = master_and_aux_intensity_r[`NIBBLE_W-1:0];

   // Any register value 0x10..0xFF has a nonzero master field
   assign pwm_run = (master_field != `MASTER_OFF);

   // --------------------------------------------------------------------
   // Pin input synchronisers
   // --------------------------------------------------------------------
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_meta_r   <= {PORTS{1'b0}};
         pin_sync_r   <= {PORTS{1'b0}};
         ninth_meta_r <= 1'b0;
         ninth_sync_r <= 1'b0;
      end else begin
         pin_meta_r   <= i_port_pin;
         pin_sync_r   <= pin_meta_r;
         ninth_meta_r <= i_ninth_output_pin;
         ninth_sync_r <= ninth_meta_r;
      end
   end

   // --------------------------------------------------------------------
   // Register writes
   // --------------------------------------------------------------------
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         master_and_aux_intensity_r <= `MASTER_AUX_RESET;
         output_intensity_a_r       <= `INTENSITY_RESET;
         output_intensity_b_r       <= `INTENSITY_RESET;
         output_intensity_c_r       <= `INTENSITY_RESET;
         output_intensity_d_r       <= `INTENSITY_RESET;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `REG_MASTER_AUX:  master_and_aux_intensity_r <= i_reg_wdata;
            `REG_INTENSITY_A: output_intensity_a_r       <= i_reg_wdata;
            `REG_INTENSITY_B: output_intensity_b_r       <= i_reg_wdata;
            `REG_INTENSITY_C: output_intensity_c_r       <= i_reg_wdata;
            `REG_INTENSITY_D: output_intensity_d_r       <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Register reads
   // --------------------------------------------------------------------
   // Unmapped addresses read as zero; data appears the edge after a read
   always @* begin
      case (i_reg_addr)
         `REG_INPUT_PORTS: rdata_nxt = pin_sync_r;
         `REG_MASTER_AUX:  rdata_nxt = master_and_aux_intensity_r;
         `REG_INTENSITY_A: rdata_nxt = output_intensity_a_r;
         `REG_INTENSITY_B: rdata_nxt = output_intensity_b_r;
         `REG_INTENSITY_C: rdata_nxt = output_intensity_c_r;
         `REG_INTENSITY_D: rdata_nxt = output_intensity_d_r;
         default:          rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
         o_reg_rdata <= rdata_nxt;
   end

   // --------------------------------------------------------------------
   // PWM timebase
   // --------------------------------------------------------------------
   pwm_slot_timer #(
      .DIV    (DIV),
      .SLOTS  (`SLOTS_PER_PERIOD),
      .CYCLES (`CYCLES_PER_SLOT)
   ) u_timer (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_run    (pwm_run),
      .o_cycle  (cycle),
      .o_slot   (slot)
   );

   // Master field m opens slots 0..m-1 of the fifteen
   assign slot_gated = (slot < master_field);

   // --------------------------------------------------------------------
   // Decoding shared by all outputs, except own_setting, which serves the ports only
   // --------------------------------------------------------------------
   // Per-output nibble: even outputs in the low half of each register
   function [3:0] own_setting;
      input integer idx;
      input [7:0]   ra;
      input [7:0]   rb;
      input [7:0]   rc;
      input [7:0]   rd;
      reg   [7:0]   sel;
      begin
         sel = ra;
         case (idx / 2)
            1:       sel = rb;
            2:       sel = rc;
            3:       sel = rd;
            default: sel = ra;
         endcase
         own_setting = (idx % 2 == 1) ? sel[7:4] : sel[3:0];
      end
   endfunction

   // Blink phase choice; phase 0 whenever blink is off
   function phase_pick;
      input p0;
      input p1;
      input blink_en;
      input flip;
      begin
         phase_pick = (blink_en && flip) ? p1 : p0;
      end
   endfunction

   // True when the pin sinks current this cycle
   function drive_low;
      input       run;
      input       gated;
      input [3:0] setting;
      input [3:0] cyc;
      input       phase;
      reg         active_time;
      begin
         active_time = 1'b0;
         if (!run)
            active_time = 1'b1;
         else if (setting == `STATIC_SETTING)
            active_time = 1'b1;
         else
            active_time = gated && (cyc <= setting);
         // Inside the active time the pin follows the phase bit, otherwise its inverse
         drive_low = active_time ? !phase : phase;
      end
   endfunction

   // --------------------------------------------------------------------
   // Port outputs zero to seven
   // --------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PORTS; g = g + 1) begin : g_port
         wire [3:0] setting;
         wire       phase;
         // Global flag swaps in the shared nibble for every output at once
         assign setting = i_global_enable ? aux_field :
                          own_setting(g, output_intensity_a_r, output_intensity_b_r,
                                      output_intensity_c_r, output_intensity_d_r);
         // All eight ports draw from the same phase registers
         assign phase = phase_pick(i_phase0[g], i_phase1[g], i_blink_enable, i_blink_flip);
         assign port_drive_nxt[g] = drive_low(pwm_run, slot_gated, setting, cycle, phase);
      end
   endgenerate

   // --------------------------------------------------------------------
   // Ninth output
   // --------------------------------------------------------------------
   // Own phase bits; its enable is registered on the same edge as the ports
   assign ninth_drive_nxt = drive_low(pwm_run, slot_gated, aux_field, cycle,
                                      phase_pick(i_ninth_phase0, i_ninth_phase1,
                                                 i_blink_enable, i_blink_flip));

   // --------------------------------------------------------------------
   // Output enables
   // --------------------------------------------------------------------
   // Registered so a static output never glitches while the decoder settles
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_port_oe         <= {PORTS{1'b0}};
         o_ninth_output_oe <= 1'b0;
      end else begin
         o_port_oe         <= port_drive_nxt;
         o_ninth_output_oe <= ninth_drive_nxt;
      end
   end

endmodule // led_pwm_intensity_control

// ===== dv/led_load_model.sv
// Pulled-up LED loads at the open-drain port pins and the ninth output
module led_load_model #(
   parameter integer PORTS = 8
) (
   input  wire logic [PORTS-1:0] i_port_oe,
   input  wire logic             i_ninth_oe,
   output logic      [PORTS-1:0] o_port_pin,
   output logic                  o_ninth_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-up lifts a released pin; a driven pin sinks to ground
   assign o_port_pin  = ~i_port_oe;
   assign o_ninth_pin = ~i_ninth_oe;
endmodule // led_load_model

// ===== dv/led_pwm_checker_assertions.sv
// Port-level checker for the LED PWM intensity controller
module led_pwm_checker #(
   parameter integer DIV   = 2,
   parameter integer PORTS = 8
) (
   input wire logic             i_clock,
   input wire logic             i_resetn,
   input wire logic             i_reg_wr,
   input wire logic             i_reg_rd,
   input wire logic [7:0]       i_reg_addr,
   input wire logic [7:0]       i_reg_wdata,
   input wire logic [7:0]       o_reg_rdata,
   input wire logic             i_global_enable,
   input wire logic             i_blink_enable,
   input wire logic             i_blink_flip,
   input wire logic [PORTS-1:0] i_phase0,
   input wire logic [PORTS-1:0] i_phase1,
   input wire logic             i_ninth_phase0,
   input wire logic             i_ninth_phase1,
   input wire logic [PORTS-1:0] o_port_oe,
   input wire logic             o_ninth_output_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HOLD_MAX = 240 * DIV + 2;
   logic [7:0]       m_r;
   logic [7:0]       ia_r;
   logic [19:0]      hold_r;
   logic             prev_r;
   logic [PORTS-1:0] sel;
   logic             sel8;
   logic [3:0]       s0;
   logic [3:0]       s1;
   logic             mapped;
   // ------------------------------------------------------------
   // Shadow of the master/aux and intensity A registers that steer the outputs
   // ------------------------------------------------------------
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         m_r    <= 8'h00;
         ia_r   <= 8'h00;
         hold_r <= 20'h00000;
         prev_r <= 1'b0;
      end else begin
         if (i_reg_wr && i_reg_addr == 8'h0E) m_r <= i_reg_wdata;
         if (i_reg_wr && i_reg_addr == 8'h10) ia_r <= i_reg_wdata;
         prev_r <= o_port_oe[0];
         // Run length of an unchanged PWM output
         hold_r <= (m_r[7:4] == 4'h0 || s0 == 4'hF || prev_r != o_port_oe[0]) ? 20'h00000 : hold_r + 20'h00001;
      end
   end
   assign sel    = (i_blink_enable && i_blink_flip) ? i_phase1 : i_phase0;
   assign sel8   = (i_blink_enable && i_blink_flip) ? i_ninth_phase1 : i_ninth_phase0;
   assign s0     = i_global_enable ? m_r[3:0] : ia_r[3:0];
   assign s1     = i_global_enable ? m_r[3:0] : ia_r[7:4];
   assign mapped = i_reg_addr == 8'h00 || i_reg_addr == 8'h0E || (i_reg_addr >= 8'h10 && i_reg_addr <= 8'h13);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   master_off_static_a: assert property (
      $past(i_resetn) && $past(m_r[7:4] == 4'h0) |-> o_port_oe == ~$past(sel) && o_ninth_output_oe == !$past(sel8))
      else $error("outputs not static while master is off");
   static_setting_a: assert property (
      $past(i_resetn) && $past(s0 == 4'hF) |-> o_port_oe[0] == !$past(sel[0]))
      else $error("port zero not static at setting F");
   ninth_static_a: assert property (
      $past(i_resetn) && $past(m_r[3:0] == 4'hF) |-> o_ninth_output_oe == !$past(sel8))
      else $error("ninth output not static at setting F");
   global_uniform_a: assert property (
      $past(i_global_enable && sel == {PORTS{sel[0]}}) |-> o_port_oe == {PORTS{o_port_oe[0]}})
      else $error("global control gave unequal ports");
   ports_together_a: assert property (
      $past(s0 == s1 && sel[1] == sel[0]) |-> o_port_oe[1] == o_port_oe[0])
      else $error("equal ports switched apart");
   blink_phase_a: assert property (
      $past(i_resetn) && $past(m_r[7:4] == 4'h0 && i_blink_enable && i_blink_flip) |-> o_port_oe == ~$past(i_phase1))
      else $error("flip did not select phase one");
   pwm_alive_a: assert property (hold_r <= HOLD_MAX)
      else $error("PWM output stuck longer than a period");
   master_readback_a: assert property (
      i_reg_rd && i_reg_addr == 8'h0E |=> o_reg_rdata == $past(m_r))
      else $error("master register read back wrong");
   unmapped_read_a: assert property (
      i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // led_pwm_checker

// ===== dv/tb.sv
// Self-checking testbench for the LED PWM intensity controller
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam integer DIV = 2;
   logic       i_clock, i_resetn, i_reg_wr, i_reg_rd, i_global_enable, i_blink_enable, i_blink_flip;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_phase0, i_phase1, i_port_pin, o_port_oe;
   logic       i_ninth_phase0, i_ninth_phase1, i_ninth_output_pin, o_ninth_output_oe, o_ninth_output_out;
   logic [7:0] o_port_out;
   int         n_mismatch = 0;
   int         checked = 0;
   led_pwm_intensity_control #(.DIV(DIV), .PORTS(8)) u_dut (.i_clock, .i_resetn, .i_reg_wr, .i_reg_rd,
      .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_global_enable, .i_blink_enable, .i_blink_flip, .i_phase0,
      .i_phase1, .i_ninth_phase0, .i_ninth_phase1, .i_port_pin, .o_port_out, .o_port_oe,
      .i_ninth_output_pin, .o_ninth_output_out, .o_ninth_output_oe);
   led_load_model #(.PORTS(8)) u_load (.i_port_oe(o_port_oe), .i_ninth_oe(o_ninth_output_oe),
      .o_port_pin(i_port_pin), .o_ninth_pin(i_ninth_output_pin));
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      i_reg_wr = 1'b1; i_reg_addr = a; i_reg_wdata = d;
      @(negedge i_clock);
      i_reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_clock);
      i_reg_rd = 1'b1; i_reg_addr = a;
      @(negedge i_clock);
      i_reg_rd = 1'b0;
      `CHK(o_reg_rdata, e)
   endtask
   // Clocks with the output driven low over one PWM period
   function automatic int exp_lo(input logic [7:0] m, input logic [3:0] s, input logic p);
      int act_steps;
      act_steps = (m[7:4] == 4'h0 || s == 4'hF) ? 240 : int'(m[7:4]) * (int'(s) + 1);
      return (p ? 240 - act_steps : act_steps) * DIV;
   endfunction
   task automatic run_case(input logic [7:0] m, ia, input logic g, be, fl, p0, p1, n0, n1);
      int c0, c1, c8;
      logic sp, s8;
      wr(8'h0E, m);
      wr(8'h10, ia);
      @(negedge i_clock);
      i_global_enable = g; i_blink_enable = be; i_blink_flip = fl;
      i_phase0 = {8{p0}}; i_phase1 = {8{p1}}; i_ninth_phase0 = n0; i_ninth_phase1 = n1;
      repeat (8) @(negedge i_clock);
      c0 = 0; c1 = 0; c8 = 0;
      repeat (240 * DIV) begin
         @(negedge i_clock);
         c0 += int'(o_port_oe[0] === 1'b1);
         c1 += int'(o_port_oe[1] === 1'b1);
         c8 += int'(o_ninth_output_oe === 1'b1);
      end
      sp = (be && fl) ? p1 : p0;
      s8 = (be && fl) ? n1 : n0;
      `CHK(c0, exp_lo(m, g ? m[3:0] : ia[3:0], sp))
      `CHK(c1, exp_lo(m, g ? m[3:0] : ia[7:4], sp))
      `CHK(c8, exp_lo(m, m[3:0], s8))
      `CHK({o_port_out, o_ninth_output_out}, 9'h000)
   endtask
   task automatic end_of_test;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #2000000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      i_resetn = 1'b0; i_reg_wr = 1'b0; i_reg_rd = 1'b0; i_reg_addr = 8'h00; i_reg_wdata = 8'h00;
      i_global_enable = 1'b0; i_blink_enable = 1'b0; i_blink_flip = 1'b0; i_phase0 = 8'h00;
      i_phase1 = 8'h00; i_ninth_phase0 = 1'b0; i_ninth_phase1 = 1'b0;
      repeat (2) @(negedge i_clock);
      i_resetn = 1'b1;
      rd(8'h0E, 8'h00);
      for (int a = 8'h10; a <= 8'h13; a++) rd(8'(a), 8'h00);
      rd(8'h55, 8'h00);
      // Port pins sit low while the static outputs sink
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      for (int a = 8'h10; a <= 8'h13; a++) wr(8'(a), 8'(a) ^ 8'h5A);
      for (int a = 8'h10; a <= 8'h13; a++) rd(8'(a), 8'(a) ^ 8'h5A);
      run_case(8'h05, 8'h30, 1, 0, 0, 0, 0, 0, 0);
      run_case(8'h05, 8'h30, 0, 1, 1, 0, 1, 0, 1);
      run_case(8'h10, 8'h00, 0, 0, 0, 0, 0, 0, 0);
      run_case(8'hF5, 8'hFE, 0, 0, 0, 0, 0, 0, 0);
      run_case(8'hF5, 8'hFE, 0, 0, 0, 1, 0, 0, 0);
      run_case(8'hFF, 8'h0F, 0, 0, 0, 0, 0, 1, 0);
      run_case(8'h37, 8'hFF, 1, 0, 0, 0, 0, 0, 0);
      run_case(8'h37, 8'hFF, 1, 1, 1, 0, 1, 0, 1);
      run_case(8'h37, 8'hFF, 1, 1, 0, 1, 0, 1, 0);
      rd(8'h0E, 8'h37);
      end_of_test();
   end
endmodule // tb
bind led_pwm_intensity_control led_pwm_checker #(.DIV(DIV), .PORTS(PORTS)) u_chk (.i_clock, .i_resetn,
   .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_global_enable, .i_blink_enable,
   .i_blink_flip, .i_phase0, .i_phase1, .i_ninth_phase0, .i_ninth_phase1, .o_port_oe, .o_ninth_output_oe);
